// File: owc_pkg.sv
// Purpose: constants and types of the warm-up counter
// Assumes: 32-bit AXI4-Lite register bus, 25 MHz aclk
// Notes: source clocks arrive as sampled pins
package owc_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFF_LOWER_CTL = 8'h00;
    localparam logic [7:0] OFF_UPPER_CTL = 8'h04;
    localparam logic [7:0] OFF_COMPARE = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h18;
    localparam logic [7:0] OFF_SYSCTL = 8'h1c;
    // ****************************************
    // field layout of the timer controls
    // ****************************************
    localparam int MODE_LSB = 0;
    localparam int RUN_BIT = 3;
    localparam int SRC_LSB = 4;
    localparam int FF_INIT_BIT = 7;
    localparam logic [2:0] LOWER_MODE_CASCADE = 3'h3;
    localparam logic [2:0] UPPER_MODE_WARMUP = 3'h5;
    localparam logic [2:0] SRC_SLOW = 3'h4;
    localparam logic [2:0] SRC_FAST = 3'h6;
    // system control bits
    localparam int SYS_FAST_EN_BIT = 7;
    localparam int SYS_SLOW_EN_BIT = 6;
    localparam int SYS_CLK_SEL_BIT = 5;
    // ****************************************
    // reset values and answers
    // ****************************************
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [7:0] SYSCTL_RESET = 8'h80;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int IRQ_MATCH_BIT = 0;
    // warm-up granularity: one compare step is 256 source ticks
    localparam int TICKS_PER_STEP = 256;
    // counter states
    typedef enum logic [1:0] {
        CNT_IDLE = 2'b01,
        CNT_RUN = 2'b10
    } owc_cnt_e;
endpackage

// File: owc_top.sv
// What this block does
// [RULE_01] two 8-bit timers form one 16-bit counter
// [RULE_02] times slow or fast oscillator warm-up
// [RULE_03] software keeps both flip-flop init bits zero
// [RULE_04] match uses only compare upper eight bits
// [RULE_05] software enables slow oscillator before start
// [RULE_06] on match clear counter, raise interrupt
// [RULE_07] software starts by setting run bit
// [RULE_08] after slow warm-up: stop, select slow, stop fast
// [RULE_09] software enables fast oscillator before start
// [RULE_10] after fast warm-up: stop, select fast, stop slow
// [RULE_11] slow warm-up spans 256 to 65280 ticks
// [RULE_12] fast warm-up spans 256 to 65280 ticks
// [RULE_13] lower control 43h selects slow cascade
// [RULE_14] lower control 63h selects fast cascade
// [RULE_15] upper control 05h selects warm-up mode
// [RULE_16] upper control bit 3 runs the counter
// [RULE_17] counter counts source ticks from zero
// [RULE_18] stopped counter holds and raises nothing
//
// Purpose: warm-up counter with AXI4-Lite registers
// Assumes: source clocks well below half of aclk
// Notes: one struct holds all state
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module owc_top
    import owc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic slow_clock,
    input wire logic fast_clock,
    output logic match_interrupt,
    output logic fast_osc_enable,
    output logic slow_osc_enable,
    output logic clock_select_slow
);

    // ****************************************
    // state record
    // ****************************************
    typedef struct packed {
        logic [2:0] sync_slow; // pin synchroniser
        logic [2:0] sync_fast; // pin synchroniser
        logic lvl_slow; // accepted level
        logic lvl_fast; // accepted level
        logic [7:0] lower_ctl; // lower_timer_control
        logic [7:0] upper_ctl; // upper_timer_control
        logic [15:0] compare; // compare_high/low_byte
        logic [15:0] count; // cascaded counter
        owc_cnt_e cnt_st; // idle or counting
        logic [7:0] sysctl; // system_control_two
        logic irq_status; // sticky match flag
        logic irq_enable; // match mask
        logic irq; // interrupt output
        logic aw_have; // address held
        logic [7:0] aw_addr;
        logic w_have; // data held
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } owc_state_s;

    owc_state_s st_q;
    owc_state_s st_d;

    // ****************************************
    // helpers
    // ****************************************
    // accepted level and rising tick from a three-stage chain;
    // only stages two and three are looked at
    function automatic logic [1:0] owc_edge(
        input logic [2:0] s,
        input logic lvl
    );
        logic nl;
        nl = (s[1] == s[2]) ? s[1] : lvl;
        return {nl, nl & ~lvl};
    endfunction

    // byte-lane merge of a write into a register word
    function automatic logic [31:0] owc_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // next-state logic
    // ****************************************
    // one process covers bus, sampling and counting, so a
    // write and a counter event in one cycle resolve in one place
    always_comb begin
        logic [1:0] es;
        logic [1:0] ef;
        logic tick;
        logic warm;
        logic start;
        logic match_set;
        logic clr;
        logic do_wr;
        logic [15:0] nxt;
        logic [31:0] m;
        es = 2'h0;
        ef = 2'h0;
        tick = 1'b0;
        warm = 1'b0;
        start = 1'b0;
        match_set = 1'b0;
        clr = 1'b0;
        do_wr = 1'b0;
        nxt = 16'h0000;
        m = 32'h0;
        st_d = st_q;

        // pin sampling through three flops
        st_d.sync_slow = {st_q.sync_slow[1:0], slow_clock};
        st_d.sync_fast = {st_q.sync_fast[1:0], fast_clock};
        es = owc_edge(st_q.sync_slow, st_q.lvl_slow);
        ef = owc_edge(st_q.sync_fast, st_q.lvl_fast);
        st_d.lvl_slow = es[1];
        st_d.lvl_fast = ef[1];

        // source select; other sources give no tick here
        case (st_q.lower_ctl[SRC_LSB +: 3])
            SRC_SLOW: tick = es[0]; // [RULE_02] [RULE_13]
            SRC_FAST: tick = ef[0]; // [RULE_02] [RULE_14]
            default: tick = 1'b0;
        endcase

        // both halves must agree on the cascade warm-up mode
        warm = (st_q.lower_ctl[MODE_LSB +: 3] == LOWER_MODE_CASCADE)
            && (st_q.upper_ctl[MODE_LSB +: 3]
                == UPPER_MODE_WARMUP); // [RULE_01] [RULE_15]

        // ****************************************
        // counter
        // ****************************************
        case (st_q.cnt_st)
            CNT_IDLE: begin
                // held value stays readable while stopped
                start = warm && st_q.upper_ctl[RUN_BIT]; // [RULE_16]
                if (start) begin
                    st_d.count = 16'h0000; // [RULE_17]
                    st_d.cnt_st = CNT_RUN;
                end
            end
            CNT_RUN: begin
                if (!warm || !st_q.upper_ctl[RUN_BIT]) begin
                    st_d.cnt_st = CNT_IDLE; // [RULE_18]
                end else if (tick) begin
                    nxt = st_q.count + 16'h0001; // [RULE_17]
                    // low compare byte takes no part
                    if (nxt[15:8] == st_q.compare[15:8]) begin // [RULE_04]
                        st_d.count = 16'h0000; // [RULE_06]
                        match_set = 1'b1; // [RULE_06] [RULE_11] [RULE_12]
                    end else begin
                        st_d.count = nxt; // [RULE_01]
                    end
                end
            end
            default: begin
                st_d.cnt_st = CNT_IDLE;
            end
        endcase

        // ****************************************
        // write channel
        // ****************************************
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_have = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        // perform when both halves are held
        do_wr = st_q.aw_have && st_q.w_have && !st_q.bvalid;
        if (do_wr) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = RESP_OKAY;
            case (st_q.aw_addr)
                OFF_LOWER_CTL: begin
                    m = owc_merge({24'h0, st_q.lower_ctl},
                        st_q.w_data, st_q.w_strb);
                    st_d.lower_ctl = m[7:0];
                end
                OFF_UPPER_CTL: begin
                    m = owc_merge({24'h0, st_q.upper_ctl},
                        st_q.w_data, st_q.w_strb);
                    st_d.upper_ctl = m[7:0]; // [RULE_16]
                end
                OFF_COMPARE: begin
                    m = owc_merge({16'h0, st_q.compare},
                        st_q.w_data, st_q.w_strb);
                    st_d.compare = m[15:0];
                end
                OFF_IRQ_ENABLE: begin
                    if (st_q.w_strb[0]) begin
                        st_d.irq_enable = st_q.w_data[IRQ_MATCH_BIT];
                    end
                end
                OFF_IRQ_CLEAR: begin
                    clr = st_q.w_strb[0]
                        && st_q.w_data[IRQ_MATCH_BIT];
                end
                OFF_SYSCTL: begin
                    m = owc_merge({24'h0, st_q.sysctl},
                        st_q.w_data, st_q.w_strb);
                    st_d.sysctl = m[7:0];
                end
                OFF_COUNT, OFF_IRQ_STATUS: begin
                    // read-only: write ignored
                    st_d.bresp = RESP_OKAY;
                end
                default: begin
                    st_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        // one transaction in flight keeps the slave simple
        st_d.awready = !st_d.aw_have && !st_d.bvalid;
        st_d.wready = !st_d.w_have && !st_d.bvalid;

        // ****************************************
        // interrupt
        // ****************************************
        // a match in the clearing cycle survives
        st_d.irq_status = (st_q.irq_status & ~clr) | match_set; // [RULE_06]
        st_d.irq = st_d.irq_status && st_d.irq_enable; // [RULE_06]

        // ****************************************
        // read channel
        // ****************************************
        if (s_axi_arvalid && st_q.arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = RESP_OKAY;
            case (s_axi_araddr)
                OFF_LOWER_CTL: st_d.rdata = {24'h0, st_q.lower_ctl};
                OFF_UPPER_CTL: st_d.rdata = {24'h0, st_q.upper_ctl};
                OFF_COMPARE: st_d.rdata = {16'h0, st_q.compare};
                OFF_COUNT: st_d.rdata = {16'h0, st_q.count};
                OFF_IRQ_STATUS: st_d.rdata = {31'h0, st_q.irq_status};
                OFF_IRQ_ENABLE: st_d.rdata = {31'h0, st_q.irq_enable};
                OFF_IRQ_CLEAR: st_d.rdata = 32'h0;
                OFF_SYSCTL: st_d.rdata = {24'h0, st_q.sysctl};
                default: begin
                    st_d.rdata = 32'h0;
                    st_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        st_d.arready = !st_d.rvalid;
    end

    // ****************************************
    // state register
    // ****************************************
    // synchronous reset loads constants only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            st_q.lower_ctl <= CTL_RESET;
            st_q.upper_ctl <= CTL_RESET;
            st_q.compare <= COMPARE_RESET;
            st_q.cnt_st <= CNT_IDLE;
            st_q.sysctl <= SYSCTL_RESET;
            st_q.bresp <= RESP_OKAY;
            st_q.rresp <= RESP_OKAY;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs, all from flops
    // ****************************************
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready = st_q.wready;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign match_interrupt = st_q.irq;
    // oscillator and clock-select bits drive the clock switch
    assign fast_osc_enable = st_q.sysctl[SYS_FAST_EN_BIT]; // [RULE_08]
    assign slow_osc_enable = st_q.sysctl[SYS_SLOW_EN_BIT]; // [RULE_10]
    assign clock_select_slow = st_q.sysctl[SYS_CLK_SEL_BIT];

endmodule // owc_top

// File: owc_props.sv
// Purpose: handshake and pin checks of the warm-up counter top
// Assumes: one clock domain, sync active-low reset
// Notes: sees only top ports; bound after endmodule
`timescale 1ns/1ns
module owc_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic match_interrupt,
    input wire logic clock_select_slow
);
    // ****************************************
    // handshake steps
    // ****************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write halves taken at one edge
    sequence wr_take_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // read address taken
    sequence rd_take_s;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ****************************************
    // properties
    // ****************************************
    // both halves are held one cycle before the write lands
    write_answer_a: assert property (wr_take_s |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid)
        else $error("write answer dropped");
    write_block_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not reopened");
    read_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
        else $error("read answer late");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    r_release_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not reopened");
    clk_select_a: assert property (
        $changed(clock_select_slow) |-> s_axi_bvalid)
        else $error("clock select moved without write");
    // irq only drops through a clear or enable write, never by itself
    irq_drop_a: assert property (
        $fell(match_interrupt) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt dropped without write");
endmodule // owc_chk
bind owc_top owc_chk owc_chk_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .match_interrupt(match_interrupt),
    .clock_select_slow(clock_select_slow));

// File: tb.sv
// Purpose: self-checking bench of the warm-up counter
// Assumes: source pins toggled at 8 aclk per tick
// Notes: bready and rready stay high; the master never holds them low
`timescale 1ns/1ns
module tb import owc_pkg::*;;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic [1:0] pin = 2'h0; // bit 0 slow source, bit 1 fast source
    logic awready, wready, bvalid, arready, rvalid;
    logic irq, fen, sen, sel;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    owc_top owc_top_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .slow_clock(pin[0]), .fast_clock(pin[1]),
        .match_interrupt(irq), .fast_osc_enable(fen),
        .slow_osc_enable(sen), .clock_select_slow(sel));
    always #20 aclk = ~aclk;
    // hang guard: whole run is well under 20k cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // pins move on the same edge the write lands; waiting two leaves margin
    task automatic pins(input logic [3:0] e);
        repeat (2) @(posedge aclk);
        chk({28'h0, irq, fen, sen, sel}, {28'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = RESP_OKAY);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er = RESP_OKAY);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    // one source tick: 4 cycles high, 4 low, clear of the 3-flop filter
    task automatic tick(input int p, input int n);
        repeat (n) begin
            pin[p] <= 1'b1;
            repeat (4) @(posedge aclk);
            pin[p] <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd(OFF_SYSCTL, {24'h0, SYSCTL_RESET});
        rd(OFF_COMPARE, {16'h0, COMPARE_RESET});
        pins(4'b0100);
        $display("test reset done");
    endtask
    task automatic t_bus();
        wr(8'h20, 32'h1, RESP_SLVERR);
        rd(8'h20, 32'h0, RESP_SLVERR);
        wr(OFF_COUNT, 32'h55);
        rd(OFF_IRQ_CLEAR, 32'h0);
        $display("test bus done");
    endtask
    // full warm-up: hold while stopped, exact match count, handler steps
    task automatic t_warm(input int p, input logic [7:0] lc, hi,
        input logic [7:0] pre, mid, post, input logic [3:0] e1, e2);
        int n;
        n = int'(hi) * TICKS_PER_STEP;
        wr(OFF_SYSCTL, {24'h0, pre});
        wr(OFF_LOWER_CTL, {24'h0, lc});
        wr(OFF_UPPER_CTL, 32'h05);
        wr(OFF_COMPARE, {16'h0, hi, 8'hff});
        wr(OFF_IRQ_ENABLE, 32'h1);
        wr(OFF_UPPER_CTL, 32'h0d);
        tick(p, 100);
        wr(OFF_UPPER_CTL, 32'h05);
        // high byte zero would match on the very next tick if running
        wr(OFF_COMPARE, 32'h0);
        tick(p, 2);
        rd(OFF_COUNT, 32'd100);
        rd(OFF_IRQ_STATUS, 32'h0);
        wr(OFF_COMPARE, {16'h0, hi, 8'hff});
        wr(OFF_UPPER_CTL, 32'h0d);
        tick(p, n - 1);
        rd(OFF_COUNT, 32'(n - 1));
        rd(OFF_IRQ_STATUS, 32'h0);
        tick(p, 1);
        rd(OFF_IRQ_STATUS, 32'h1);
        rd(OFF_COUNT, 32'h0);
        wr(OFF_UPPER_CTL, 32'h05);
        wr(OFF_SYSCTL, {24'h0, mid});
        pins(e1);
        wr(OFF_SYSCTL, {24'h0, post});
        pins(e2);
        wr(OFF_IRQ_ENABLE, 32'h0);
        pins(e2 & 4'b0111);
        wr(OFF_IRQ_CLEAR, 32'h1);
        wr(OFF_IRQ_ENABLE, 32'h1);
        pins(e2 & 4'b0111);
        rd(OFF_IRQ_STATUS, 32'h0);
        $display("test warm-up on source %0d done", p);
    endtask
    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_bus();
        t_warm(0, 8'h43, 8'h01, 8'hc0, 8'he0, 8'h60, 4'hf, 4'hb);
        t_warm(1, 8'h63, 8'h02, 8'he0, 8'hc0, 8'h80, 4'he, 4'hc);
        results();
    end
endmodule // tb
